// ### dv/fds_drive_model.sv
// Drive-side model: free-running reference clock and active low raw pulse stream
`default_nettype none
module fds_drive_model (
  // Clock
  input  wire logic clk,
  // Drive side outputs
  output wire logic ref_clk,
  output wire logic raw_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half period in clk cycles, about 7.8 MHz
  localparam int HALF_REF = 16;
  logic [3:0] ref_cnt_q = 4'h0;
  logic       ref_q     = 1'b0;
  logic       raw_q     = 1'b1;

  // One writer per signal; the ports only follow
  assign ref_clk = ref_q;
  assign raw_b   = raw_q;

  // Reference runs free; the system owns it, not the drive
  always @(posedge clk) begin
    ref_cnt_q <= ref_cnt_q + 4'h1;
    if (ref_cnt_q == 4'(HALF_REF - 1)) begin
      ref_q <= ~ref_q;
    end
  end

  // One combined clock-or-data pulse, low 30 clk, kept under one tick
  task automatic pulse();
    @(posedge clk);
    raw_q <= 1'b0;
    repeat (30) @(posedge clk);
    raw_q <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### dv/test_fds_pulse_separator.sv
// Self-checking bench for the floppy pulse separator
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("MISMATCH %0t %s", $time, msg); \
    end \
  end
module test_fds_pulse_separator
  import fds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REF_P = 32;
  logic clk;
  logic rst_b;
  logic ref_clk;
  logic raw_b;
  logic sel_lo;
  logic sel_hi;
  logic win;
  logic bits;
  int   err_count;
  int   checks;

  fds_drive_model drv (.clk(clk), .ref_clk(ref_clk), .raw_b(raw_b));
  fds_pulse_separator dut_u (
    .clk                (clk),
    .rst_b              (rst_b),
    .raw_disk_pulses_b  (raw_b),
    .reference_clock_in (ref_clk),
    .divisor_select_low (sel_lo),
    .divisor_select_high(sel_hi),
    .window_clock_out   (win),
    .recovered_bits_out (bits)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Sampled on the falling edge so registered outputs have settled
  task automatic wait_lvl(input logic v, inout int n);
    while (win !== v) begin
      @(negedge clk);
      n++;
      if (n > 20000) begin
        err_count++;
        $display("MISMATCH %0t window clock stuck", $time);
        wrap_up();
      end
    end
  endtask

  task automatic period(inout int n);
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
  endtask

  task automatic do_reset(input logic [1:0] d);
    @(posedge clk);
    rst_b  <= 1'b0;
    sel_hi <= d[1];
    sel_lo <= d[0];
    repeat (10) @(posedge clk);
    `CHK(win, 1'b1, "window level in reset")
    `CHK(bits, 1'b0, "data level in reset")
    rst_b <= 1'b1;
  endtask

  task automatic t_div();
    int n;
    for (int d = 0; d < 4; d++) begin
      do_reset(d[1:0]);
      n = 0;
      period(n);
      n = 0;
      period(n);
      `CHK(n, (FDS_NOMINAL_COUNT * REF_P) << d, "uncorrected period")
    end
    $display("t_div done");
  endtask

  task automatic t_data();
    int n;
    do_reset(2'b00);
    n = 0;
    period(n);
    repeat (10 * REF_P) @(posedge clk);
    drv.pulse();
    // Negedges already gone by since the window rose
    n = 10 * REF_P + 30;
    period(n);
    `CHK(n, FDS_NOMINAL_COUNT * REF_P, "mid pulse leaves period")
    repeat (4) @(negedge clk);
    `CHK(bits, 1'b1, "data bit after low-half pulse")
    n = 4;
    period(n);
    `CHK(n, FDS_NOMINAL_COUNT * REF_P, "empty window period")
    repeat (4) @(negedge clk);
    `CHK(bits, 1'b0, "no data bit in empty window")
    $display("t_data done");
  endtask

  // Pulses always early or always late pull the window both ways
  task automatic t_corr(input int at, input logic late);
    int   n;
    logic in_range;
    do_reset(2'b00);
    n = 0;
    period(n);
    for (int i = 0; i < 6; i++) begin
      repeat (at * REF_P) @(posedge clk);
      drv.pulse();
      // Negedges already gone by since the window rose
      n = at * REF_P + 30;
      period(n);
      in_range = (n >= FDS_MIN_COUNT * REF_P) && (n <= FDS_MAX_COUNT * REF_P);
      `CHK(in_range, 1'b1, "period bound")
    end
    `CHK(n > FDS_NOMINAL_COUNT * REF_P, late, "correction direction")
    $display("t_corr done");
  endtask

  initial begin
    rst_b     = 1'b0;
    sel_lo    = 1'b0;
    sel_hi    = 1'b0;
    err_count = 0;
    checks    = 0;
    t_div();
    t_data();
    t_corr(0, 1'b0);
    t_corr(13, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire

// ### src/fds_divider.sv
// Reference clock divider producing a one-cycle internal clock tick
`default_nettype none
module fds_divider
  import fds_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Ratio select, synchronised by caller
  input  wire logic [1:0] div_sel,
  // One-cycle strobe per reference rise
  input  wire logic       step,
  // Internal clock tick
  output logic            tick
);
  logic [FDS_DIV_W-1:0] div_q;
  logic [FDS_DIV_W-1:0] div_d;
  logic [FDS_DIV_W-1:0] div_mask;
  logic                 wrap;
  logic [FDS_DIV_W-1:0] seen_q;
  logic [1:0]           sel_prev_q;
  logic                 moved_q;

  // Ratio 1,2,4,8 means wrap on mask 0,1,3,7
  assign div_mask = (div_sel == 2'(FDS_DIV1)) ? 3'h0 :
                    (div_sel == 2'(FDS_DIV2)) ? 3'h1 :
                    (div_sel == 2'(FDS_DIV4)) ? 3'h3 : 3'h7;
  assign wrap     = ((div_q & div_mask) == div_mask);
  // Counts reference rises, not system clocks; the flop still runs every edge
  assign div_d    = !step ? div_q : (wrap ? FDS_DIV_RST : div_q + 3'h1);
  assign tick     = step && wrap;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= FDS_DIV_RST;
    end else begin
      div_q <= div_d;
    end
  end

  // Check helpers: rises since the last tick, and whether the ratio moved meanwhile
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_q     <= FDS_DIV_RST;
      sel_prev_q <= 2'h0;
      moved_q    <= 1'b0;
    end else begin
      seen_q     <= tick ? FDS_DIV_RST : (step ? seen_q + 3'h1 : seen_q);
      sel_prev_q <= div_sel;
      moved_q    <= (div_sel != sel_prev_q) || (moved_q && !tick);
    end
  end

  a_div_period: assert property (@(posedge clk) disable iff (!rst_b)
    (tick && !moved_q && div_sel == sel_prev_q)
      |-> seen_q == 3'((4'h1 << div_sel) - 4'h1))
    else $error("divide ratio wrong");
endmodule
`default_nettype wire

// ### src/fds_pkg.sv
// Package of constants and types for the floppy pulse separator
`default_nettype none
package fds_pkg;
  localparam int          FDS_NOMINAL_COUNT = 16;
  localparam int          FDS_MIN_COUNT     = 12;
  localparam int          FDS_MAX_COUNT     = 22;
  localparam int          FDS_CNT_W         = 5;
  localparam int          FDS_DRIFT_W       = 3;
  localparam int          FDS_DIV_W         = 3;
  localparam logic [4:0]  FDS_CNT_RST       = 5'h00;
  localparam logic [2:0]  FDS_DRIFT_RST     = 3'h0;
  localparam logic [2:0]  FDS_DIV_RST       = 3'h0;
  localparam int          FDS_DRIFT_LIMIT   = 3;
  localparam int          FDS_SHORT_STEP    = 2;
  typedef enum logic [1:0] {
    FDS_DIV1,
    FDS_DIV2,
    FDS_DIV4,
    FDS_DIV8
  } fds_div_type;
endpackage
`default_nettype wire

// ### src/fds_pulse_separator.sv
// Digital data separator: window clock and recovered bits from raw pulses
//
// Operation
// - The internal clock is the reference clock divided by 1, 2, 4 or 8 chosen by two pins.
// - Leading edges of raw disk pulses shift the phase of the window clock.
// - Without correction a window clock period lasts sixteen internal clock periods.
// - A corrected period never lasts fewer than twelve or more than twenty-two internal periods.
// - A short-term corrector acts per pulse and a long-term corrector tracks sustained drift.
// - The window clock and recovered data bits are both derived from the one pulse stream.
`default_nettype none
module fds_pulse_separator
  import fds_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Drive side, active low pulses
  input  wire logic raw_disk_pulses_b,
  // Reference clock level, sampled
  input  wire logic reference_clock_in,
  // Ratio select pins
  input  wire logic divisor_select_low,
  input  wire logic divisor_select_high,
  // Controller side
  output logic      window_clock_out,
  output logic      recovered_bits_out
);
  import fds_pkg::*;

  // Two-stage synchronisers for all input pins except rst_b, which resets directly
  logic       dsk_s1_q, dsk_s2_q, ref_s1_q, ref_s2_q;
  logic [1:0] sel_s1_q, sel_s2_q;
  logic       dsk_prev_q, ref_prev_q;
  logic       ref_rise;
  logic       pulse_edge;
  logic       int_tick;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dsk_s1_q <= 1'b1;
      dsk_s2_q <= 1'b1;
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      sel_s1_q <= 2'h0;
      sel_s2_q <= 2'h0;
    end else begin
      dsk_s1_q <= raw_disk_pulses_b;
      dsk_s2_q <= dsk_s1_q;
      ref_s1_q <= reference_clock_in;
      ref_s2_q <= ref_s1_q;
      sel_s1_q <= {divisor_select_high, divisor_select_low};
      sel_s2_q <= sel_s1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dsk_prev_q <= 1'b1;
      ref_prev_q <= 1'b0;
    end else begin
      dsk_prev_q <= dsk_s2_q;
      ref_prev_q <= ref_s2_q;
    end
  end

  // Leading edge is the falling edge of the active-low pulse
  assign pulse_edge = dsk_prev_q && !dsk_s2_q;
  assign ref_rise   = ref_s2_q && !ref_prev_q;

  // Divider steps on reference rises; its tick is the internal clock
  fds_divider u_div (
    .clk     (clk),
    .rst_b   (rst_b),
    .div_sel (sel_s2_q),
    .step    (ref_rise),
    .tick    (int_tick)
  );

  // Window counter state
  logic [FDS_CNT_W-1:0]   cnt_q, cnt_d;
  logic [FDS_CNT_W-1:0]   len_q, len_d;
  logic signed [FDS_DRIFT_W-1:0] drift_q, drift_d;
  logic                   win_q, win_d;
  logic                   data_seen_q, data_seen_d;
  logic                   bit_q, bit_d;
  logic                   edge_pend_q;
  logic                   period_end;
  logic                   half_point;
  logic                   early, late;
  logic [FDS_CNT_W-1:0]   base_len;
  logic [FDS_CNT_W-1:0]   short_len;

  // Edge held until the next internal tick so none is lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_pend_q <= 1'b0;
    end else begin
      edge_pend_q <= pulse_edge || (edge_pend_q && !int_tick);
    end
  end

  // Early edge: seen in first quarter of window; late: in last quarter
  assign early      = (cnt_q < (len_q >> 2));
  assign late       = (cnt_q >= (len_q - (len_q >> 2)));
  assign period_end = (cnt_q == len_q - 5'h01);
  assign half_point = (cnt_q == (len_q >> 1) - 5'h01);
  // Long-term corrector shifts base length by accumulated drift
  assign base_len   = 5'(FDS_NOMINAL_COUNT + int'(drift_q));

  // Short-term corrector trims this period only, clamped to legal bounds
  always_comb begin
    short_len = base_len;
    if (edge_pend_q && early) begin
      short_len = base_len - 5'(FDS_SHORT_STEP);
    end else if (edge_pend_q && late) begin
      short_len = base_len + 5'(FDS_SHORT_STEP);
    end
    if (short_len < 5'(FDS_MIN_COUNT)) begin
      short_len = 5'(FDS_MIN_COUNT);
    end else if (short_len > 5'(FDS_MAX_COUNT)) begin
      short_len = 5'(FDS_MAX_COUNT);
    end
  end

  always_comb begin
    cnt_d       = cnt_q;
    len_d       = len_q;
    drift_d     = drift_q;
    win_d       = win_q;
    data_seen_d = data_seen_q;
    bit_d       = bit_q;
    if (int_tick) begin
      if (edge_pend_q) begin
        len_d = short_len;
        // Sustained drift nudges the long-term term one step at a time
        if (early && drift_q > -3'(FDS_DRIFT_LIMIT)) begin
          drift_d = drift_q - 3'sh1;
        end else if (late && drift_q < 3'(FDS_DRIFT_LIMIT)) begin
          drift_d = drift_q + 3'sh1;
        end
        // Pulses in the data half of the window are data bits
        if (!win_q) begin
          data_seen_d = 1'b1;
        end
      end
      if (period_end) begin
        cnt_d       = '0;
        len_d       = edge_pend_q ? short_len : base_len;
        win_d       = 1'b1;
        bit_d       = data_seen_d;
        data_seen_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 5'h01;
        if (half_point) begin
          win_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q       <= FDS_CNT_RST;
      len_q       <= 5'(FDS_NOMINAL_COUNT);
      drift_q     <= FDS_DRIFT_RST;
      win_q       <= 1'b1;
      data_seen_q <= 1'b0;
      bit_q       <= 1'b0;
    end else begin
      cnt_q       <= cnt_d;
      len_q       <= len_d;
      drift_q     <= drift_d;
      win_q       <= win_d;
      data_seen_q <= data_seen_d;
      bit_q       <= bit_d;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      window_clock_out   <= 1'b1;
      recovered_bits_out <= 1'b0;
    end else begin
      window_clock_out   <= win_q;
      recovered_bits_out <= bit_q;
    end
  end

  // Checks
  a_len_bounds: assert property (@(posedge clk) disable iff (!rst_b)
    len_q >= 5'(FDS_MIN_COUNT) && len_q <= 5'(FDS_MAX_COUNT))
    else $error("window length out of bounds");
  a_cnt_below: assert property (@(posedge clk) disable iff (!rst_b)
    cnt_q < len_q)
    else $error("window counter passed length");
  a_wrap_rise: assert property (@(posedge clk) disable iff (!rst_b)
    (int_tick && period_end) |=> win_q && cnt_q == 5'h00)
    else $error("window did not restart");
  a_nominal_len: assert property (@(posedge clk) disable iff (!rst_b)
    (int_tick && period_end && !edge_pend_q && drift_q == 3'sh0) |=> len_q == 5'h10)
    else $error("uncorrected period not sixteen");
  a_edge_held: assert property (@(posedge clk) disable iff (!rst_b)
    pulse_edge |=> edge_pend_q)
    else $error("disk edge lost");
  a_drift_bound: assert property (@(posedge clk) disable iff (!rst_b)
    drift_q >= -3'sh3 && drift_q <= 3'sh3)
    else $error("drift out of range");
  a_out_follow: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> window_clock_out == $past(win_q) && recovered_bits_out == $past(bit_q))
    else $error("outputs not following state");
  a_early_short: assert property (@(posedge clk) disable iff (!rst_b)
    (int_tick && edge_pend_q && early && !period_end && base_len == 5'h10)
      |=> len_q == 5'h0e)
    else $error("early edge did not shorten");
  a_tick_ratio: assert property (@(posedge clk) disable iff (!rst_b)
    int_tick |-> ref_rise)
    else $error("internal tick without reference edge");

  c_edge_early: cover property (@(posedge clk) disable iff (!rst_b)
    int_tick && edge_pend_q && early);
  c_edge_late: cover property (@(posedge clk) disable iff (!rst_b)
    int_tick && edge_pend_q && late);
  c_data_bit: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(recovered_bits_out));
  c_drift_max: cover property (@(posedge clk) disable iff (!rst_b)
    drift_q == 3'sh3);
endmodule
`default_nettype wire
